// File: verilog/sosc_top.sv
module sosc_top
   import sosc_pkg::*;
#(
   parameter logic [31:0] STEP_CYCLES = SOSC_STEP_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Strap and sense pins
   input wire logic force_single_ended_strap,
   input wire logic differential_sense_line,
   input wire logic delayed_start_strap,
   input wire logic motor_enable_strap,
   input wire logic write_protect_strap,
   input wire logic parity_disable_strap,
   input wire logic [3:0] primary_id_header,
   input wire logic [3:0] auxiliary_id_header,
   // Command side of the drive
   input wire logic start_unit_cmd,
   input wire logic medium_write_req,
   input wire logic parity_error_det,
   // Outputs
   output logic lvd_mode,
   output logic spindle_run,
   output logic [3:0] bus_id,
   output logic write_accept,
   output logic write_refused,
   output logic parity_check_en,
   output logic parity_error_report,
   output logic irq
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int PIN_W = 14;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1;
   logic [PIN_W-1:0] sync2;
   logic [PIN_W-1:0] sync3;
   logic [PIN_W-1:0] pin_flt;

   assign pin_raw = {differential_sense_line, auxiliary_id_header, primary_id_header,
                     parity_disable_strap, write_protect_strap, motor_enable_strap,
                     delayed_start_strap, force_single_ended_strap};

   // Three flops per pin; the filtered value moves once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               pin_flt[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  pin_flt[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Power-up strap capture
   // ----------------------------------------
   logic [2:0] settle_cnt;
   logic latched;
   logic st_fse;
   logic st_delay;
   logic st_motor;
   logic st_wp;
   logic st_nopar;
   logic [3:0] st_id;
   logic capture;
   logic [3:0] next_id;

   assign capture = !latched && (settle_cnt == SOSC_SETTLE_CYCLES);
   assign next_id = pin_flt[8:5] | pin_flt[12:9];

   // Straps taken once after reset release, then frozen until the next reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_cnt <= 3'h0;
         latched <= 1'b0;
         st_fse <= 1'b0;
         st_delay <= 1'b0;
         st_motor <= 1'b0;
         st_wp <= 1'b0;
         st_nopar <= 1'b0;
         st_id <= 4'h0;
      end else if (capture) begin
         latched <= 1'b1;
         st_fse <= pin_flt[0];
         st_delay <= pin_flt[1];
         st_motor <= pin_flt[2];
         st_wp <= pin_flt[3];
         st_nopar <= pin_flt[4];
         st_id <= next_id;
      end else if (!latched) begin
         settle_cnt <= settle_cnt + 3'h1;
      end
   end

   // ----------------------------------------
   // Transceiver mode
   // ----------------------------------------
   logic next_lvd;

   assign next_lvd = latched && !st_fse && pin_flt[13];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvd_mode <= 1'b0;
      end else begin
         lvd_mode <= next_lvd;
      end
   end

   // ----------------------------------------
   // Spindle start sequencing
   // ----------------------------------------
   sosc_spin_t spin_st;
   sosc_spin_t next_spin_st;
   logic [31:0] step_cnt;
   logic [3:0] steps_left;
   logic step_done;
   logic sw_start;
   logic start_req;

   assign step_done = (step_cnt == STEP_CYCLES - 32'h1);
   assign start_req = start_unit_cmd || sw_start;

   // Next state of the spindle sequence
   always_comb begin
      next_spin_st = spin_st;
      case (spin_st)
         SOSC_SP_SAMPLE: begin
            if (latched) begin
               if (st_motor) begin
                  next_spin_st = SOSC_SP_WAIT_CMD;
               end else if (st_delay && st_id != 4'h0) begin
                  next_spin_st = SOSC_SP_DELAY;
               end else begin
                  next_spin_st = SOSC_SP_RUN;
               end
            end
         end
         SOSC_SP_DELAY: begin
            if (step_done && steps_left == 4'h1) begin
               next_spin_st = SOSC_SP_RUN;
            end
         end
         SOSC_SP_WAIT_CMD: begin
            if (start_req) begin
               next_spin_st = SOSC_SP_RUN;
            end
         end
         SOSC_SP_RUN: next_spin_st = SOSC_SP_RUN;
         default: next_spin_st = SOSC_SP_SAMPLE;
      endcase
   end

   // State and delay counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spin_st <= SOSC_SP_SAMPLE;
         step_cnt <= 32'h0;
         steps_left <= 4'h0;
      end else begin
         spin_st <= next_spin_st;
         if (spin_st != SOSC_SP_DELAY) begin
            step_cnt <= 32'h0;
            steps_left <= st_id;
         end else if (step_done) begin
            step_cnt <= 32'h0;
            steps_left <= steps_left - 4'h1;
         end else begin
            step_cnt <= step_cnt + 32'h1;
         end
      end
   end

   assign spindle_run = (spin_st == SOSC_SP_RUN);
   assign bus_id = st_id;

   // ----------------------------------------
   // Write protection and parity
   // ----------------------------------------
   logic next_write_accept;
   logic next_write_refused;
   logic next_parity_report;

   assign next_write_accept = medium_write_req && latched && !st_wp;
   assign next_write_refused = medium_write_req && !(latched && !st_wp);
   assign next_parity_report = parity_error_det && latched && !st_nopar;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_accept <= 1'b0;
         write_refused <= 1'b0;
         parity_error_report <= 1'b0;
         parity_check_en <= 1'b0;
      end else begin
         write_accept <= next_write_accept;
         write_refused <= next_write_refused;
         parity_error_report <= next_parity_report;
         parity_check_en <= latched && !st_nopar;
      end
   end

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic wr_ok;
   logic rd_go;
   logic [31:0] rd_value;
   logic rd_ok;
   logic [SOSC_IRQ_W-1:0] irq_status;
   logic [SOSC_IRQ_W-1:0] irq_mask;
   logic [SOSC_IRQ_W-1:0] irq_set;
   logic [SOSC_IRQ_W-1:0] irq_clr;
   logic spin_start_evt;
   logic spin_prev;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // Valid write offsets
   assign wr_ok = (aw_addr == SOSC_OFS_IRQ_STATUS) || (aw_addr == SOSC_OFS_IRQ_MASK) ||
                  (aw_addr == SOSC_OFS_CONTROL);
   assign sw_start = wr_go && (aw_addr == SOSC_OFS_CONTROL) && w_strb[0] &&
                     w_data[SOSC_CTRL_START];
   assign irq_clr = (wr_go && aw_addr == SOSC_OFS_IRQ_STATUS && w_strb[0]) ?
                    w_data[SOSC_IRQ_W-1:0] : 4'h0;

   // Read decode
   assign rd_ok = 1'b1;
   always_comb begin
      rd_value = 32'h0;
      if (s_axi_araddr == SOSC_OFS_STRAPS) begin
         rd_value[SOSC_STRAP_FSE] = st_fse;
         rd_value[SOSC_STRAP_DELAY] = st_delay;
         rd_value[SOSC_STRAP_MOTOR] = st_motor;
         rd_value[SOSC_STRAP_WP] = st_wp;
         rd_value[SOSC_STRAP_NOPAR] = st_nopar;
         rd_value[SOSC_STRAP_ID +: 4] = st_id;
      end else if (s_axi_araddr == SOSC_OFS_STATE) begin
         rd_value[SOSC_STATE_LATCHED] = latched;
         rd_value[SOSC_STATE_LVD] = lvd_mode;
         rd_value[SOSC_STATE_SPIN] = spindle_run;
         rd_value[SOSC_STATE_FSM +: 4] = spin_st;
      end else if (s_axi_araddr == SOSC_OFS_IRQ_STATUS) begin
         rd_value[SOSC_IRQ_W-1:0] = irq_status;
      end else if (s_axi_araddr == SOSC_OFS_IRQ_MASK) begin
         rd_value[SOSC_IRQ_W-1:0] = irq_mask;
      end
   end

   // Write address and data held until both are present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response and mask register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SOSC_RESP_OKAY;
         irq_mask <= SOSC_IRQ_MASK_RST;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? SOSC_RESP_OKAY : SOSC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go && aw_addr == SOSC_OFS_IRQ_MASK && w_strb[0]) begin
            irq_mask <= w_data[SOSC_IRQ_W-1:0];
         end
      end
   end

   // Read data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= SOSC_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= (s_axi_araddr <= SOSC_OFS_CONTROL && s_axi_araddr[1:0] == 2'h0 &&
                         rd_ok) ? SOSC_RESP_OKAY : SOSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign spin_start_evt = spindle_run && !spin_prev;
   assign irq_set = {next_parity_report, next_write_refused, spin_start_evt, capture};

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 4'h0;
         spin_prev <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         spin_prev <= spindle_run;
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule

// File: verilog/sosc_pkg.sv
package sosc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned SOSC_CLK_HZ = 100_000_000;
   localparam int unsigned SOSC_STEP_S = 12;
   localparam logic [31:0] SOSC_STEP_CYCLES = 32'(SOSC_STEP_S * SOSC_CLK_HZ);
   localparam logic [2:0] SOSC_SETTLE_CYCLES = 3'h4;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] SOSC_OFS_STRAPS = 8'h00;
   localparam logic [7:0] SOSC_OFS_STATE = 8'h04;
   localparam logic [7:0] SOSC_OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] SOSC_OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] SOSC_OFS_CONTROL = 8'h10;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SOSC_STRAP_FSE = 0;
   localparam int SOSC_STRAP_DELAY = 1;
   localparam int SOSC_STRAP_MOTOR = 2;
   localparam int SOSC_STRAP_WP = 3;
   localparam int SOSC_STRAP_NOPAR = 4;
   localparam int SOSC_STRAP_ID = 8;
   localparam int SOSC_STATE_LATCHED = 0;
   localparam int SOSC_STATE_LVD = 1;
   localparam int SOSC_STATE_SPIN = 2;
   localparam int SOSC_STATE_FSM = 4;
   localparam int SOSC_CTRL_START = 0;
   localparam int SOSC_IRQ_LATCHED = 0;
   localparam int SOSC_IRQ_SPIN = 1;
   localparam int SOSC_IRQ_WREFUSE = 2;
   localparam int SOSC_IRQ_PARITY = 3;
   localparam int SOSC_IRQ_W = 4;

   // ----------------------------------------
   // Reset values and responses
   // ----------------------------------------
   localparam logic [SOSC_IRQ_W-1:0] SOSC_IRQ_MASK_RST = 4'h0;
   localparam logic [1:0] SOSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SOSC_RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Spindle start states
   // ----------------------------------------
   typedef enum logic [3:0] {
      SOSC_SP_SAMPLE = 4'h1,
      SOSC_SP_DELAY = 4'h2,
      SOSC_SP_WAIT_CMD = 4'h4,
      SOSC_SP_RUN = 4'h8
   } sosc_spin_t;

endpackage

// File: bench/sosc_monitor.sv
module sosc_monitor
   import sosc_pkg::*;
#(
   parameter logic [31:0] STEP_CYCLES = SOSC_STEP_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic force_single_ended_strap,
   input wire logic differential_sense_line,
   input wire logic delayed_start_strap,
   input wire logic motor_enable_strap,
   input wire logic write_protect_strap,
   input wire logic parity_disable_strap,
   input wire logic [3:0] primary_id_header,
   input wire logic [3:0] auxiliary_id_header,
   input wire logic start_unit_cmd,
   input wire logic medium_write_req,
   input wire logic parity_error_det,
   input wire logic lvd_mode,
   input wire logic spindle_run,
   input wire logic [3:0] bus_id,
   input wire logic write_accept,
   input wire logic write_refused,
   input wire logic parity_check_en,
   input wire logic parity_error_report
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Helper
   // ------
   logic [31:0] cnt;
   logic s_fse, s_delay, s_motor, s_wp, s_nopar;
   logic [3:0] s_id;
   logic settled;
   logic [31:0] start_at;
   // Straps are steady during reset, so copy them there; count edges after it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 32'h0;
         s_fse <= force_single_ended_strap;
         s_delay <= delayed_start_strap;
         s_motor <= motor_enable_strap;
         s_wp <= write_protect_strap;
         s_nopar <= parity_disable_strap;
         s_id <= primary_id_header | auxiliary_id_header;
      end else if (cnt != 32'hFFFFFFFF) begin
         cnt <= cnt + 32'h1;
      end
   end
   // Settings are in force well after capture; earliest delayed spin-up
   assign settled = cnt >= 32'h8;
   assign start_at = 32'(s_id) * STEP_CYCLES + 32'h5;
   // ----------
   // Properties
   // ----------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence sense_steady;
      settled && !s_fse ##0 $stable(differential_sense_line) [*6];
   endsequence
   sequence write_seen;
      settled ##0 medium_write_req;
   endsequence
   force_single_a: assert property (s_fse |-> !lvd_mode)
      else $error("differential mode while single-ended forced");
   lvd_follow_a: assert property (sense_steady |-> lvd_mode == differential_sense_line)
      else $error("bus mode does not follow sense line");
   immed_spin_a: assert property (settled && !s_delay && !s_motor |-> spindle_run)
      else $error("spindle not started at once");
   cmd_only_a: assert property (s_motor && $rose(spindle_run) |-> $past(start_unit_cmd))
      else $error("spindle started without start command");
   cmd_start_a: assert property (settled && s_motor && start_unit_cmd |=> spindle_run)
      else $error("start command did not start spindle");
   delay_start_a: assert property (s_delay && !s_motor && $rose(spindle_run) |->
      cnt >= start_at && cnt <= start_at + 32'h4)
      else $error("delayed spin-up at wrong time");
   bus_id_a: assert property (settled |-> bus_id == s_id)
      else $error("bus id differs from headers");
   parity_en_a: assert property (settled |-> parity_check_en == !s_nopar)
      else $error("parity check enable wrong");
   parity_rep_a: assert property (settled && parity_error_det |=>
      parity_error_report == !s_nopar)
      else $error("parity report wrong");
   write_guard_a: assert property (write_seen |=>
      write_refused == s_wp && write_accept == !s_wp)
      else $error("write accept or refuse wrong");
endmodule

// File: bench/sosc_host_model.sv
module sosc_host_model #(
   parameter logic [3:0] HOST_ID = 4'h7
) (
   input wire logic aclk,
   input wire logic go,
   input wire logic [2:0] op,
   output logic [3:0] host_id,
   output logic start_unit_cmd = 1'h0,
   output logic medium_write_req = 1'h0,
   output logic parity_error_det = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Initiator keeps its own bus ID; drive IDs chosen by the bench differ
   assign host_id = HOST_ID;
   // One-cycle command pulses launched just after the edge that sees go
   always @(posedge aclk) begin
      start_unit_cmd <= go && op[2];
      medium_write_req <= go && op[1];
      parity_error_det <= go && op[0];
   end
endmodule

// File: bench/tb_strap_option_startup_control.sv
module tb_strap_option_startup_control import sosc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Row: straps {-,-,fse,sense,delay,motor,wp,nopar}, pid, aid, {lvd,spin30,spin60,pen}, id
   typedef struct packed {
      logic [7:0] straps;
      logic [3:0] pid;
      logic [3:0] aid;
      logic [3:0] outs;
      logic [3:0] id;
   } sosc_row_t;
   localparam logic [31:0] STEP = 32'h14;
   sosc_row_t rows [5] = '{24'h303073, 24'h170585, 24'h082032, 24'h1C1293, 24'h080070};
   sosc_row_t r;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd, exp;
   logic force_single_ended_strap = 1'h0, differential_sense_line = 1'h0;
   logic delayed_start_strap = 1'h0, motor_enable_strap = 1'h0;
   logic write_protect_strap = 1'h0, parity_disable_strap = 1'h0;
   logic [3:0] primary_id_header = 4'h0, auxiliary_id_header = 4'h0, bus_id, host_id;
   logic start_unit_cmd, medium_write_req, parity_error_det, irq;
   logic lvd_mode, spindle_run, write_accept, write_refused, parity_check_en, parity_error_report;
   logic go = 1'h0;
   logic [2:0] op = 3'h0;
   int fail_count = 0;
   int samples_checked = 0;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
   always #5 aclk = ~aclk;
   sosc_top #(.STEP_CYCLES(STEP)) sosc_top_i (.*);
   sosc_host_model sosc_host_model_i (.aclk(aclk), .go(go), .op(op), .host_id(host_id),
      .start_unit_cmd(start_unit_cmd), .medium_write_req(medium_write_req),
      .parity_error_det(parity_error_det));
   // -----
   // Tasks
   // -----
   task automatic complete_run();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Straps are set while reset is held, as at power-up
   task automatic do_reset(input logic [7:0] s, input logic [3:0] p, input logic [3:0] a);
      @(posedge aclk);
      aresetn <= 1'h0;
      {force_single_ended_strap, differential_sense_line, delayed_start_strap} <= s[5:3];
      {motor_enable_strap, write_protect_strap, parity_disable_strap} <= s[2:0];
      primary_id_header <= p;
      auxiliary_id_header <= a;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
   endtask
   // Write: decide at the falling edge what the next rising edge takes
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_t;
      logic w_t;
      logic b_t;
      int n;
      n = 0;
      b_t = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (b_t !== 1'h1 && n < 50) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'h0;
         if (w_t) s_axi_wvalid <= 1'h0;
         n++;
      end
      s_axi_bready <= 1'h0;
      if (b_t !== 1'h1) fail_count++;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ar_t;
      logic r_t;
      int n;
      n = 0;
      r_t = 1'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (r_t !== 1'h1 && n < 50) begin
         @(negedge aclk);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'h0;
         n++;
      end
      s_axi_rready <= 1'h0;
      if (r_t !== 1'h1) fail_count++;
   endtask
   // Host pulse, then stop at the falling edge where the drive answers
   task automatic host_op(input logic [2:0] o);
      @(posedge aclk);
      op <= o;
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      @(posedge aclk);
      @(negedge aclk);
   endtask
   // ----
   // Main
   // ----
   initial begin
      for (int i = 0; i < 5; i++) begin
         r = rows[i];
         do_reset(r.straps, r.pid, r.aid);
         repeat (30) @(posedge aclk);
         @(negedge aclk);
         `CHK(spindle_run, r.outs[2])
         repeat (30) @(posedge aclk);
         @(negedge aclk);
         `CHK(spindle_run, r.outs[1])
         `CHK(lvd_mode, r.outs[3])
         `CHK(parity_check_en, r.outs[0])
         `CHK(bus_id, r.id)
         `CHK(bus_id != host_id, 1'h1)
         exp = {20'h0, r.id, 3'h0, r.straps[0], r.straps[1], r.straps[2], r.straps[3],
                r.straps[5]};
         axi_rd(SOSC_OFS_STRAPS);
         `CHK(rd, exp)
         host_op(3'h3);
         `CHK(write_accept, !r.straps[1])
         `CHK(write_refused, r.straps[1])
         `CHK(parity_error_report, !r.straps[0])
         host_op(3'h4);
         `CHK(spindle_run, 1'h1)
      end
      // Straps moved after capture, masked and unmasked interrupt, bus errors
      do_reset(8'h02, 4'h1, 4'h0);
      @(negedge aclk);
      `CHK(spindle_run, 1'h0)
      `CHK(parity_check_en, 1'h0)
      repeat (12) @(posedge aclk);
      write_protect_strap <= 1'h0;
      parity_disable_strap <= 1'h1;
      axi_wr(SOSC_OFS_IRQ_MASK, 32'h4);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      `CHK(irq, 1'h0)
      host_op(3'h3);
      `CHK(write_refused, 1'h1)
      `CHK(parity_error_report, 1'h1)
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK(irq, 1'h1)
      axi_rd(SOSC_OFS_IRQ_STATUS);
      `CHK(rd, 32'hF)
      axi_wr(SOSC_OFS_IRQ_STATUS, 32'hF);
      axi_rd(SOSC_OFS_IRQ_STATUS);
      `CHK(rd, 32'h0)
      `CHK(irq, 1'h0)
      axi_rd(SOSC_OFS_IRQ_MASK);
      `CHK(rd, 32'h4)
      axi_wr(SOSC_OFS_STRAPS, 32'hFF);
      `CHK(rsp, SOSC_RESP_SLVERR)
      axi_rd(8'h40);
      `CHK(rsp, SOSC_RESP_SLVERR)
      axi_rd(SOSC_OFS_STRAPS);
      `CHK(rd, 32'h108)
      complete_run();
   end
   // Whole run is about 430 cycles; cut a hang well beyond that
   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      complete_run();
   end
endmodule
bind sosc_top sosc_monitor #(.STEP_CYCLES(STEP_CYCLES)) sosc_monitor_i (.*);
